// >>> bus_mode_pkg.sv
package bus_mode_pkg;

  // capability sense levels, as resolved by the analog front end
  typedef enum logic [1:0] {
    CAP_GROUND    = 2'h0,
    CAP_PULLDOWN  = 2'h1,
    CAP_INTERMED  = 2'h2,
    CAP_HIGH      = 2'h3
  } cap_level_t;

  typedef enum logic [1:0] {
    MODE_CONV     = 2'h0,
    MODE_PCIX1    = 2'h1,
    MODE_PCIX2    = 2'h2
  } bus_mode_t;

  typedef enum logic [1:0] {
    FREQ_33       = 2'h0,
    FREQ_66       = 2'h1,
    FREQ_100      = 2'h2,
    FREQ_133      = 2'h3
  } bus_freq_t;

  localparam logic [3:0] PAT_CONV       = 4'hF;
  localparam logic [3:0] PAT_M1_66      = 4'hE;
  localparam logic [3:0] PAT_M2_100     = 4'h5;
  localparam logic [3:0] PAT_M2_133     = 4'h4;
  localparam logic [3:0] PAT_M1_100     = 4'hD;
  localparam logic [3:0] PAT_M1_133     = 4'hC;

  // register map of the plain register port
  localparam logic [3:0] ADDR_CTRL      = 4'h0;
  localparam logic [3:0] ADDR_STATUS    = 4'h4;
  localparam int         CTRL_PAT_LSB   = 16;
  localparam int         CTRL_RST_BIT   = 21;
  localparam logic [3:0] PAT_RST        = 4'hF;
  localparam logic       BUS_RST_RST    = 1'b1;

endpackage

// >>> bus_mode_freq_init.sv
`timescale 1ns/10ps
module bus_mode_freq_init
  import bus_mode_pkg::*;
(
  // clock and reset
  input  wire logic       ref_clk,
  input  wire logic       nrst,
  // bus capability senses and straps (asynchronous pins)
  input  wire logic [1:0] pcix_capability_sense,
  input  wire logic       capability_66_sense,
  input  wire logic       mode2_sense,
  input  wire logic       mode1_speed_cap_strap_n,
  input  wire logic       mode2_speed_cap_strap_n,
  input  wire logic       endpoint_select_strap_n,
  // register port
  input  wire logic [3:0] reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic [31:0]     reg_rdata,
  // secondary bus
  output logic            bus_reset_out_n,
  output logic [3:0]      init_pattern,
  output logic            init_pattern_oe_n,
  output logic [1:0]      bus_mode,
  output logic [1:0]      bus_freq
);

  localparam int NSYNC = 8;

  typedef struct packed {
    logic [NSYNC-1:0] s1;
    logic [NSYNC-1:0] s2;
    logic [NSYNC-1:0] s3;
    logic             rst_ff;
    logic             rst_out_n_ff;
    logic             cap66_ff;
    logic [1:0]       cap_ff;
    logic [3:0]       pat_ff;
    logic             pat_wr_ff;
    logic             mode_lock_ff;
    logic [1:0]       mode_ff;
    logic [1:0]       freq_ff;
    logic [3:0]       drv_ff;
    logic             oe_n_ff;
    logic [31:0]      rdata_ff;
  } state_t;

  state_t st_ff, nxt_st;

  logic [NSYNC-1:0] raw;
  logic [NSYNC-1:0] agree;
  logic [NSYNC-1:0] val;
  logic             central;
  logic             m2s, m1cap, m2cap;
  logic [1:0]       dec_mode, dec_freq;
  logic [3:0]       dec_pat;
  logic [31:0]      ctrl_rd;

  assign raw = {endpoint_select_strap_n, mode2_speed_cap_strap_n, mode1_speed_cap_strap_n,
                mode2_sense, capability_66_sense, pcix_capability_sense, 1'b0};

  // a level or 66 sense change counts only once stages two and three agree; the other bits are used from stage three directly
  genvar gi;
  generate
    for (gi = 0; gi < NSYNC; gi++) begin : g_sync
      assign agree[gi] = (st_ff.s2[gi] == st_ff.s3[gi]);
      assign val[gi]   = st_ff.s3[gi];
    end
  endgenerate

  assign central = val[7];
  assign m2cap   = val[6];
  assign m1cap   = val[5];
  assign m2s     = val[4];

  // decode uses only the row's own inputs
  always_comb begin
    dec_mode = MODE_PCIX1;
    dec_freq = FREQ_66;
    dec_pat  = PAT_M1_66;
    unique case (cap_level_t'(st_ff.cap_ff))
      CAP_GROUND: begin
        dec_mode = MODE_CONV;
        dec_freq = st_ff.cap66_ff ? FREQ_66 : FREQ_33;
        dec_pat  = PAT_CONV;
      end
      CAP_PULLDOWN: begin
        if (m2s) begin
          dec_mode = MODE_PCIX2;
          dec_freq = m2cap ? FREQ_133 : FREQ_100;
          dec_pat  = m2cap ? PAT_M2_133 : PAT_M2_100;
        end else begin
          dec_mode = MODE_PCIX1;
          dec_freq = FREQ_66;
          dec_pat  = PAT_M1_66;
        end
      end
      CAP_INTERMED: begin
        dec_mode = MODE_PCIX1;
        dec_freq = FREQ_66;
        dec_pat  = PAT_M1_66;
      end
      CAP_HIGH: begin
        // the strap caps a 133-capable card too, for loaded slots
        dec_mode = MODE_PCIX1;
        dec_freq = m1cap ? FREQ_133 : FREQ_100;
        dec_pat  = m1cap ? PAT_M1_133 : PAT_M1_100;
      end
    endcase
  end

  always_comb begin
    ctrl_rd = 32'h0;
    ctrl_rd[CTRL_PAT_LSB +: 4] = st_ff.pat_ff;
    ctrl_rd[CTRL_RST_BIT]      = st_ff.rst_ff;
  end

  always_comb begin
    nxt_st    = st_ff;
    nxt_st.s1 = raw;
    nxt_st.s2 = st_ff.s1;
    nxt_st.s3 = st_ff.s2;
    // sample the senses only while the bus is held in reset
    // both level bits must have settled, or a level change can tear
    if (st_ff.rst_ff && agree[1] && agree[2]) begin
      nxt_st.cap_ff = st_ff.s3[2:1];
    end
    if (st_ff.rst_ff && agree[3]) begin
      nxt_st.cap66_ff = st_ff.s3[3];
    end
    // default pattern tracks the decode until software writes it
    if (st_ff.rst_ff && !st_ff.pat_wr_ff) begin
      nxt_st.pat_ff = dec_pat;
    end
    if (reg_wr && reg_addr == ADDR_CTRL) begin
      if (st_ff.rst_ff) begin
        nxt_st.pat_ff    = reg_wdata[CTRL_PAT_LSB +: 4];
        nxt_st.pat_wr_ff = 1'b1;
      end
      nxt_st.rst_ff = reg_wdata[CTRL_RST_BIT];
    end
    // fixed once on the falling edge of reset
    if (st_ff.rst_ff && !nxt_st.rst_ff) begin
      nxt_st.mode_ff      = dec_mode;
      nxt_st.freq_ff      = dec_freq;
      nxt_st.mode_lock_ff = 1'b1;
    end
    if (!st_ff.rst_ff && nxt_st.rst_ff) begin
      nxt_st.mode_lock_ff = 1'b0;
      nxt_st.pat_wr_ff    = 1'b0;
    end
    // endpoint mode never drives the pattern
    nxt_st.rst_out_n_ff = !nxt_st.rst_ff;
    nxt_st.drv_ff  = st_ff.pat_ff;
    nxt_st.oe_n_ff = !(central && st_ff.rst_ff);
    nxt_st.rdata_ff = 32'h0;
    if (reg_rd) begin
      unique case (reg_addr)
        ADDR_CTRL:   nxt_st.rdata_ff = ctrl_rd;
        ADDR_STATUS: nxt_st.rdata_ff = {23'h0, central, st_ff.mode_lock_ff, st_ff.cap66_ff,
                                        st_ff.cap_ff, st_ff.mode_ff, st_ff.freq_ff};
        default:     nxt_st.rdata_ff = 32'h0;
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      st_ff         <= '0;
      st_ff.rst_ff  <= BUS_RST_RST;
      st_ff.pat_ff  <= PAT_RST;
      st_ff.oe_n_ff <= 1'b1;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // reset output follows the control reset bit, whether central resource or endpoint
  assign reg_rdata         = st_ff.rdata_ff;
  assign bus_reset_out_n   = st_ff.rst_out_n_ff;
  assign init_pattern      = st_ff.drv_ff;
  assign init_pattern_oe_n = st_ff.oe_n_ff;
  assign bus_mode          = st_ff.mode_ff;
  assign bus_freq          = st_ff.freq_ff;

endmodule

// >>> bus_mode_freq_init_sva.sv
`timescale 1ns/10ps
module bus_mode_freq_init_sva
  import bus_mode_pkg::*;
(
  // clock and reset
  input logic        ref_clk,
  input logic        nrst,
  // strap and register port
  input logic        endpoint_select_strap_n,
  input logic [3:0]  reg_addr,
  input logic [31:0] reg_wdata,
  input logic        reg_wr,
  input logic        reg_rd,
  input logic [31:0] reg_rdata,
  // secondary bus
  input logic        bus_reset_out_n,
  input logic [3:0]  init_pattern,
  input logic        init_pattern_oe_n,
  input logic [1:0]  bus_mode,
  input logic [1:0]  bus_freq
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!nrst);
  wire ctl_wr = reg_wr && reg_addr == ADDR_CTRL;
  // pattern only driven while the bus was in reset
  drive_in_rst_a: assert property (!init_pattern_oe_n |-> !$past(bus_reset_out_n)) else $error("drive out of reset");
  rst_ctl_a: assert property (ctl_wr |=> bus_reset_out_n == !$past(reg_wdata[CTRL_RST_BIT])) else $error("reset bit");
  mode_hold_a: assert property (bus_reset_out_n [*2] |-> $stable(bus_mode)) else $error("mode moved");
  freq_hold_a: assert property (bus_reset_out_n [*2] |-> $stable(bus_freq)) else $error("freq moved");
  pat_hold_a: assert property (bus_reset_out_n [*3] |-> $stable(init_pattern)) else $error("pattern moved");
  // endpoint strap must settle through the sync flops first
  endpoint_quiet_a: assert property (!endpoint_select_strap_n [*6] |-> init_pattern_oe_n) else $error("endpoint drives");
  rdata_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0) else $error("rdata not idle");
  status_rd_a: assert property (reg_rd && reg_addr == ADDR_STATUS |=> reg_rdata[3:0] == {$past(bus_mode), $past(bus_freq)})
    else $error("status mismatch");
  cover property (bus_reset_out_n && bus_mode == MODE_PCIX2);
  cover property (!init_pattern_oe_n);
  cover property (ctl_wr && !reg_wdata[CTRL_RST_BIT]);
endmodule
bind bus_mode_freq_init bus_mode_freq_init_sva chk (.*);

// >>> adapter_straps_model.sv
`timescale 1ns/10ps
module adapter_straps_model (
  // board configuration
  input  logic [5:0] setup,
  // senses and straps
  output logic [1:0] pcix_capability_sense,
  output logic       capability_66_sense,
  output logic       mode2_sense,
  output logic       mode1_speed_cap_strap_n,
  output logic       mode2_speed_cap_strap_n
);
  // pins always at a valid level, never floated
  assign {pcix_capability_sense, capability_66_sense, mode2_sense} = setup[5:2];
  assign {mode1_speed_cap_strap_n, mode2_speed_cap_strap_n} = setup[1:0];
endmodule

// >>> test_bus_mode_freq_init.sv
`timescale 1ns/10ps
module test_bus_mode_freq_init;
  import bus_mode_pkg::*;
  logic ref_clk = 0, nrst = 0, ep = 1, endpoint_select_strap_n = 1, reg_wr = 0, reg_rd = 0;
  logic [3:0] reg_addr = 4'h0, p;
  logic [31:0] reg_wdata = 32'h0, reg_rdata, d;
  logic [5:0] setup = 6'h0;
  logic [7:0] lf = 8'h47, e;
  logic [1:0] cap, bus_mode, bus_freq;
  logic m66, m2, s1, s2, bus_reset_out_n, init_pattern_oe_n;
  logic [3:0] init_pattern;
  int fails = 0, n_tests = 0;
  always #12.5 ref_clk = ~ref_clk;
  adapter_straps_model far (.setup(setup), .pcix_capability_sense(cap), .capability_66_sense(m66),
    .mode2_sense(m2), .mode1_speed_cap_strap_n(s1), .mode2_speed_cap_strap_n(s2));
  bus_mode_freq_init dut (.*, .pcix_capability_sense(cap), .capability_66_sense(m66), .mode2_sense(m2),
    .mode1_speed_cap_strap_n(s1), .mode2_speed_cap_strap_n(s2));
  // reference decode: {mode, freq, pattern}
  function automatic logic [7:0] dec(logic [1:0] c, logic a66, logic b2, logic c1, logic c2);
    if (c == 2'h0) return a66 ? 8'h1F : 8'h0F;
    if (c == 2'h2 || (c == 2'h1 && !b2)) return 8'h5E;
    if (c == 2'h1) return c2 ? 8'hB4 : 8'hA5;
    return c1 ? 8'h7C : 8'h6D;
  endfunction
  task print_verdict;
    $display("tests %0d fails %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task chk(logic [31:0] g, logic [31:0] x);
    n_tests++;
    if (g !== x) begin
      fails++;
      $display("[ERR] %0t got %h exp %h", $time, g, x);
    end
  endtask
  task wr(logic [3:0] a, logic [31:0] v);
    @(posedge ref_clk);
    reg_addr <= a; reg_wdata <= v; reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask
  task rd(logic [3:0] a);
    @(posedge ref_clk);
    reg_addr <= a; reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    @(negedge ref_clk) d = reg_rdata;
  endtask
  initial begin
    repeat (2000) @(posedge ref_clk);
    fails++;
    print_verdict;
  end
  initial begin
    repeat (3) @(posedge ref_clk);
    nrst <= 1'b1;
    for (int i = 0; i < 16; i++) begin
      lf = {lf[6:0], lf[7] ^ lf[5] ^ lf[4] ^ lf[3]};
      ep = (i != 5);
      e = dec(i[1:0], lf[3], lf[2], lf[1], lf[0]);
      p = lf[4] ? lf[7:4] : e[3:0];
      @(posedge ref_clk);
      setup <= {i[1:0], lf[3:0]};
      endpoint_select_strap_n <= ep;
      if (i > 0) wr(ADDR_CTRL, 32'h0020_0000);
      repeat (8) @(posedge ref_clk);
      chk(init_pattern_oe_n, !ep);
      if (lf[4]) wr(ADDR_CTRL, {12'h002, p, 16'h0});
      repeat (2) @(posedge ref_clk);
      @(negedge ref_clk);
      if (ep) chk(init_pattern, p);
      wr(ADDR_CTRL, {12'h000, p, 16'h0});
      @(negedge ref_clk);
      chk(bus_reset_out_n, 1);
      if (ep) chk({bus_mode, bus_freq}, e[7:4]);
      @(posedge ref_clk);
      setup <= ~setup;
      repeat (6) @(posedge ref_clk);
      rd(ADDR_STATUS);
      if (ep) chk({d[3:0], init_pattern}, {e[7:4], p});
    end
    rd(4'h8);
    chk(d, 0);
    print_verdict;
  end
endmodule
